// ---- hw/vpic_pkg.sv ----
// Package: register map, field positions and reset values of the status block
// What this block does
// - Clear register bit 4 written 1 clears error flag; 0 no effect.
// - Bits 3..0 written 1 clear that channel frame flag (bit 1 not at format 3h); 0 no effect.
// - Error and channel 3, 1, 0 clear bits are write-only.
// - Channel 2 clear bit is write-only like the others; reads zero.
// - Raw mode: bit 1 is line control at format 3h, frame at 0.
// - Free-run bit 0 low: the suspend input halts the port.
// - Free-run bit high: every suspend request is ignored.
// - Channel frame flag sets on frame sync regardless of enable (channel 1 only at format 0); sticky.
// - Error flag sets on detected error regardless of enable; sticky.
package vpic_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_CLEAR = 4'h4;
  localparam logic [3:0] OFF_EMU = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hC;
  localparam int BIT_ERR = 4;
  localparam int BIT_CH1 = 1;
  localparam int BIT_FREE = 0;
  localparam int NFLAG = 5;
  localparam logic [2:0] FMT_LINE = 3'h3;
  localparam logic [2:0] FMT_FRAME = 3'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic EMU_RST = 1'b0;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vpic_req_t;
  typedef struct packed {
    logic [3:0] frame_sync;
    logic line_sync;
    logic error;
  } vpic_evt_t;
endpackage

// ---- hw/vpic_top.sv ----
// Module: interrupt flags, flag clear register and emulation suspend control
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module vpic_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire vpic_pkg::vpic_req_t bus,
  output logic [31:0] rdata,
  input wire vpic_pkg::vpic_evt_t evt,
  input wire logic [2:0] chan0_capture_format,
  input wire logic emu_suspend,
  output logic halt,
  output logic irq,
  output logic line_irq_clear
);
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic [4:0] sticky_r;
  logic [4:0] mask_r;
  logic free_r;
  logic [31:0] rdata_r;
  logic susp_m_r;
  logic susp_s_r;
  logic halt_r;
  logic lclr_r;

  // Address decode
  wire wr_clear = bus.wr && bus.addr == vpic_pkg::OFF_CLEAR;
  wire wr_emu = bus.wr && bus.addr == vpic_pkg::OFF_EMU;
  wire wr_mask = bus.wr && bus.addr == vpic_pkg::OFF_MASK;
  wire rd_flags = bus.rd && bus.addr == vpic_pkg::OFF_FLAGS;
  wire line_mode = chan0_capture_format == vpic_pkg::FMT_LINE;
  wire frame_mode = chan0_capture_format == vpic_pkg::FMT_FRAME;
  // Clear pulses; ch1 bit goes to line control in line mode
  wire [4:0] clr_bits = wr_clear ? bus.wdata[4:0] : 5'h00;
  wire [4:0] clr_flag = line_mode ? (clr_bits & 5'h1D) : clr_bits;
  // Hardware events, ch1 line sync counts only in line mode
  wire [3:0] fs = {evt.frame_sync[3:2],
    (frame_mode & evt.frame_sync[1]) | (line_mode & evt.line_sync),
    evt.frame_sync[0]};
  wire [4:0] set_bits = {evt.error, fs};
  // Set wins over clear
  assign flags_nxt = (flags_r & ~clr_flag) | set_bits;
  // Interrupt-side sticky copy, cleared by reading the flag register
  wire [4:0] sticky_nxt = (rd_flags ? 5'h00 : sticky_r) | set_bits;

  // Flag and sticky state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_r <= vpic_pkg::FLAGS_RST;
      sticky_r <= vpic_pkg::FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
      sticky_r <= sticky_nxt;
    end
  end

  // Software registers; reserved bits dropped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_r <= vpic_pkg::MASK_RST;
      free_r <= vpic_pkg::EMU_RST;
    end else begin
      if (wr_mask) mask_r <= bus.wdata[4:0];
      if (wr_emu) free_r <= bus.wdata[vpic_pkg::BIT_FREE];
    end
  end

  // Read mux; clear register always reads zero
  wire [31:0] rd_mux =
    (bus.addr == vpic_pkg::OFF_FLAGS) ? {27'h0, flags_r} :
    (bus.addr == vpic_pkg::OFF_EMU) ? {31'h0, free_r} :
    (bus.addr == vpic_pkg::OFF_MASK) ? {27'h0, mask_r} :
    32'h0;

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rdata_r <= 32'h0;
    else rdata_r <= bus.rd ? rd_mux : 32'h0;
  end

  // Suspend input synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      susp_m_r <= 1'b0;
      susp_s_r <= 1'b0;
    end else begin
      susp_m_r <= emu_suspend;
      susp_s_r <= susp_m_r;
    end
  end

  // Halt and line clear pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      halt_r <= 1'b0;
      lclr_r <= 1'b0;
    end else begin
      halt_r <= susp_s_r && !free_r;
      lclr_r <= line_mode && clr_bits[vpic_pkg::BIT_CH1];
    end
  end

  assign rdata = rdata_r;
  assign halt = halt_r;
  assign line_irq_clear = lclr_r;
  assign irq = |(sticky_r & mask_r);

  // Checks
  a_err_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear && bus.wdata[4] && !evt.error |=> !flags_r[4])
    else $error("error flag not cleared");
  a_zero_keeps: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear && !bus.wdata[0] && flags_r[0] |=> flags_r[0])
    else $error("zero write cleared flag");
  a_clear_reads: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus.rd && bus.addr == vpic_pkg::OFF_CLEAR |=> rdata == 32'h0)
    else $error("clear register readable");
  a_ch2_reads: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus.rd && bus.addr == vpic_pkg::OFF_CLEAR |=> !rdata[2])
    else $error("ch2 clear readable");
  a_line_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    line_mode && wr_clear && bus.wdata[1] |=> line_irq_clear)
    else $error("line clear missing");
  a_halt_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    emu_suspend && !free_r && !wr_emu ##1 !free_r ##1 !free_r
    |=> halt)
    else $error("suspend not honoured");
  a_free_run: assert property (@(posedge clk_sys) disable iff (!nrst)
    free_r && $past(free_r) |-> !halt)
    else $error("halted in free run");
  a_frame_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt.frame_sync[3] |=> flags_r[3] && sticky_r[3])
    else $error("frame flag not set");
  a_error_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_r[4] && !clr_flag[4] |=> flags_r[4])
    else $error("error flag lost");
  a_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(bus.rd) |-> rdata[31:5] == 27'h0)
    else $error("reserved bits nonzero");
  // Channel 0 clear honoured when no sync arrives alongside
  a_ch0_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear && bus.wdata[0] && !evt.frame_sync[0] |=> !flags_r[0])
    else $error("channel 0 flag not cleared");
  // Same-cycle error event beats the clear write
  a_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear && bus.wdata[4] && evt.error |=> flags_r[4])
    else $error("event lost to clear");
  // Line mode leaves the channel 1 flag alone on a clear
  a_line_keeps: assert property (@(posedge clk_sys) disable iff (!nrst)
    line_mode && wr_clear && bus.wdata[1] && flags_r[1]
    |=> flags_r[1])
    else $error("line mode cleared ch1 flag");
  // Free-run bit follows bit 0 of a write only
  a_free_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_emu |=> free_r == $past(bus.wdata[0]))
    else $error("free run bit not written");
  // Read data bus idles at zero outside the answer cycle
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !bus.rd |=> rdata == 32'h0)
    else $error("read data outside answer cycle");
  // Reading the flags drops the interrupt copy when no event is due
  a_sticky_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_flags && set_bits == 5'h00 |=> sticky_r == 5'h00)
    else $error("interrupt copy not cleared");
  c_irq: cover property (@(posedge clk_sys) disable iff (!nrst) irq);
  c_line_clr: cover property (@(posedge clk_sys) disable iff (!nrst)
    line_irq_clear);
  c_halt: cover property (@(posedge clk_sys) disable iff (!nrst) halt);
  c_set_clr: cover property (@(posedge clk_sys) disable iff (!nrst)
    evt.error && clr_flag[4]);
endmodule
`default_nettype wire

// ---- testbench/vpic_top_test.sv ----
// Testbench: flag set and clear, line mode, interrupt, emulation suspend
`timescale 1ns/10ps
`default_nettype none
module vpic_top_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  vpic_pkg::vpic_req_t bus = '0;
  vpic_pkg::vpic_evt_t evt = '0;
  logic [2:0] fmt = 3'h0;
  logic emu_suspend = 1'b0;
  logic [31:0] rdata;
  logic halt, irq, line_irq_clear;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  // Clock and hang guard
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end
  vpic_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata),
    .evt(evt), .chan0_capture_format(fmt), .emu_suspend(emu_suspend),
    .halt(halt), .irq(irq), .line_irq_clear(line_irq_clear));
  // Compare and count
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle bus strobes
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus.rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clk_sys) evt <= e;
    @(posedge clk_sys) evt <= '0;
    #1;
  endtask
  task automatic t_flags();
    rd(vpic_pkg::OFF_FLAGS, 32'h0);
    pulse(6'h3D);
    rd(vpic_pkg::OFF_FLAGS, 32'h1F);
    rd(vpic_pkg::OFF_CLEAR, 32'h0);
    wr(vpic_pkg::OFF_CLEAR, 32'hFFFFFFE0);
    rd(vpic_pkg::OFF_FLAGS, 32'h1F);
    wr(vpic_pkg::OFF_CLEAR, 32'h10);
    rd(vpic_pkg::OFF_FLAGS, 32'h0F);
    wr(vpic_pkg::OFF_CLEAR, 32'h05);
    rd(vpic_pkg::OFF_FLAGS, 32'h0A);
    wr(vpic_pkg::OFF_CLEAR, 32'h0A);
    rd(vpic_pkg::OFF_FLAGS, 32'h0);
  endtask
  task automatic t_irq();
    wr(vpic_pkg::OFF_MASK, 32'hFFFFFFFF);
    rd(vpic_pkg::OFF_MASK, 32'h1F);
    pulse(6'h01);
    check(irq, 1'b1);
    wr(vpic_pkg::OFF_MASK, 32'h0);
    check(irq, 1'b0);
    wr(vpic_pkg::OFF_MASK, 32'h10);
    check(irq, 1'b1);
    rd(vpic_pkg::OFF_FLAGS, 32'h10);
    check(irq, 1'b0);
    wr(vpic_pkg::OFF_CLEAR, 32'h10);
  endtask
  task automatic t_line();
    @(posedge clk_sys) fmt <= vpic_pkg::FMT_LINE;
    pulse(6'h08);
    rd(vpic_pkg::OFF_FLAGS, 32'h0);
    pulse(6'h02);
    rd(vpic_pkg::OFF_FLAGS, 32'h02);
    wr(vpic_pkg::OFF_CLEAR, 32'h02);
    check(line_irq_clear, 1'b1);
    rd(vpic_pkg::OFF_FLAGS, 32'h02);
    @(posedge clk_sys) fmt <= vpic_pkg::FMT_FRAME;
    wr(vpic_pkg::OFF_CLEAR, 32'h02);
    check(line_irq_clear, 1'b0);
    rd(vpic_pkg::OFF_FLAGS, 32'h0);
    pulse(6'h08);
    rd(vpic_pkg::OFF_FLAGS, 32'h02);
  endtask
  task automatic t_emu();
    @(posedge clk_sys) emu_suspend <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 check(halt, 1'b1);
    wr(vpic_pkg::OFF_EMU, 32'hFFFFFFFF);
    rd(vpic_pkg::OFF_EMU, 32'h1);
    repeat (5) @(posedge clk_sys);
    #1 check(halt, 1'b0);
  endtask
  // Event and clear in one cycle, then an unsupported format
  task automatic t_race();
    @(posedge clk_sys) begin
      bus <= '{addr: vpic_pkg::OFF_CLEAR, wdata: 32'h10, wr: 1'b1, rd: 1'b0};
      evt <= 6'h01;
    end
    @(posedge clk_sys) begin
      bus.wr <= 1'b0;
      evt <= '0;
    end
    #1;
    rd(vpic_pkg::OFF_FLAGS, 32'h12);
    @(posedge clk_sys) fmt <= 3'h1;
    wr(vpic_pkg::OFF_CLEAR, 32'h12);
    pulse(6'h0A);
    rd(vpic_pkg::OFF_FLAGS, 32'h0);
  endtask
  // Closing report
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_flags();
    t_irq();
    t_line();
    t_emu();
    t_race();
    print_verdict();
  end
endmodule
`default_nettype wire
